// ==== drive_run_defs.vh ====
// Purpose: Constants for the drive run command and step select logic
// Assumes: Included by bare name from the frequency select and run command select design files
// Notes: Overview list below; codes are terminal function selections
//
// Overview of operation
// - Three step terminals form index, highest step code is MSB, steps 0 to 7.
// - Function code 5 is step LSB, 6 middle bit, 7 MSB.
// - Step zero uses the normal frequency source and frequency command.
// - Steps 1-3 use drive-group presets, steps 4-7 use I/O-group presets.
// - Mode 0: run key starts acceleration, stop key starts deceleration.
// - Keypad mode direction from select: F forward, R reverse.
// - Function code 0 is forward run input, code 1 reverse run input.
// - Mode 1: only forward active runs forward, only reverse runs reverse.
// - Mode 1: both inputs active or both inactive stops the motor.
// - Mode 2: forward input is run/stop, reverse input picks direction.
// - Direction disable 0 allows both, 1 blocks forward, 2 blocks reverse.
// - Power-on start set in terminal mode runs if run terminal already active.
// - Power-on start setting ignored in keypad mode 0.
// - Fault restart set in terminal mode runs at fault clear if terminal active.
// - Fault restart setting ignored in keypad mode 0.
`ifndef DRIVE_RUN_DEFS_VH
`define DRIVE_RUN_DEFS_VH
`define MODE_KEYPAD 2'h0
`define MODE_TERM_FR 2'h1
`define MODE_TERM_RD 2'h2
`define FUNC_FWD 5'h00
`define FUNC_REV 5'h01
`define FUNC_STEP_L 5'h05
`define FUNC_STEP_M 5'h06
`define FUNC_STEP_H 5'h07
`define DIS_NONE 2'h0
`define DIS_FWD 2'h1
`define DIS_REV 2'h2
`define FUNC_W 5
`define FREQ_W 16
`endif

// ==== term_function_map.v ====
// Purpose: Finds terminals carrying a given function code and ORs their levels
// Assumes: Five multi-function inputs with 5-bit codes packed low to high
// Notes: Registered output
`timescale 1ns/1ps
`default_nettype none
module term_function_map #(
  parameter N = 5,
  parameter W = 5
) (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire [N-1:0] i_levels,
  input wire [N*W-1:0] i_codes,
  input wire [W-1:0] i_match,
  output reg o_active
);
  wire [N-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_term
      assign hit[g] = i_levels[g] && (i_codes[g*W +: W] == i_match);
    end
  endgenerate
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_active <= 1'b0;
    end else begin
      o_active <= |hit;
    end
  end
endmodule
`default_nettype wire

// ==== step_freq_select.v ====
// Purpose: Picks output frequency from step index
// Assumes: Presets held stable by the parameter store
// Notes: Output registered
`timescale 1ns/1ps
`default_nettype none
`include "drive_run_defs.vh"
module step_freq_select #(
  parameter FW = `FREQ_W
) (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire [2:0] i_step,
  input wire [FW-1:0] i_base_freq,
  input wire [8*FW-1:0] i_presets,
  output reg [FW-1:0] o_freq
);
  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_freq <= {FW{1'b0}};
    end else if (i_step == 3'h0) begin
      o_freq <= i_base_freq;
    end else begin
      o_freq <= i_presets[i_step*FW +: FW];
    end
  end
endmodule
`default_nettype wire

// ==== drive_run_command_select.v ====
// Purpose: Run command, direction and multi-step frequency selection
// Assumes: Inputs synchronous and debounced; keys are one-cycle pulses
// Notes: Auto start flags act only in terminal drive modes
`timescale 1ns/1ps
`default_nettype none
`include "drive_run_defs.vh"
module drive_run_command_select #(
  parameter FW = `FREQ_W
) (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_multi_input_1,
  input wire i_multi_input_2,
  input wire i_multi_input_3,
  input wire i_multi_input_4,
  input wire i_multi_input_5,
  input wire [24:0] i_input_function_codes,
  input wire [1:0] i_drive_mode,
  input wire i_keypad_direction_select,
  input wire [1:0] i_direction_disable,
  input wire i_power_on_autostart,
  input wire i_fault_clear_autorestart,
  input wire i_run_key,
  input wire i_stop_key,
  input wire i_fault_active,
  input wire [FW-1:0] i_base_freq,
  input wire [3*FW-1:0] i_preset_freq_1_to_3,
  input wire [4*FW-1:0] i_preset_freq_4_to_7,
  output reg o_run,
  output reg o_reverse,
  output wire [2:0] o_step,
  output wire [FW-1:0] o_freq
);
  localparam ST_INIT = 3'b001;
  localparam ST_NORM = 3'b010;
  localparam ST_HOLD = 3'b100;

  wire [4:0] levels = {i_multi_input_5, i_multi_input_4, i_multi_input_3,
                       i_multi_input_2, i_multi_input_1};
  wire fwd_in;
  wire rev_in;
  wire [2:0] step_bits;
  reg [2:0] state;
  reg [2:0] next_state;
  reg key_run;
  reg next_key_run;
  reg key_rev;
  reg fault_d;
  reg maps_ready;
  reg next_run;
  reg next_reverse;
  reg term_run;
  reg term_rev;
  reg want_run;
  reg want_rev;
  wire term_mode = (i_drive_mode == `MODE_TERM_FR) || (i_drive_mode == `MODE_TERM_RD);
  wire fault_cleared = fault_d && !i_fault_active;

  term_function_map #(.N(5), .W(`FUNC_W)) u_fwd (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_levels(levels),
    .i_codes(i_input_function_codes), .i_match(`FUNC_FWD), .o_active(fwd_in));
  term_function_map #(.N(5), .W(`FUNC_W)) u_rev (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_levels(levels),
    .i_codes(i_input_function_codes), .i_match(`FUNC_REV), .o_active(rev_in));
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_step
      localparam [4:0] STEP_CODE = `FUNC_STEP_L + g;
      term_function_map #(.N(5), .W(`FUNC_W)) u_bit (
        .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_levels(levels),
        .i_codes(i_input_function_codes),
        .i_match(STEP_CODE),
        .o_active(step_bits[g]));
    end
  endgenerate
  assign o_step = step_bits;

  step_freq_select #(.FW(FW)) u_freq (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_step(step_bits),
    .i_base_freq(i_base_freq),
    .i_presets({i_preset_freq_4_to_7, i_preset_freq_1_to_3, {FW{1'b0}}}),
    .o_freq(o_freq)
  );

  // Terminal run request and direction
  always @* begin
    term_run = 1'b0;
    term_rev = 1'b0;
    if (i_drive_mode == `MODE_TERM_FR) begin
      term_run = fwd_in ^ rev_in;
      term_rev = rev_in && !fwd_in;
    end else if (i_drive_mode == `MODE_TERM_RD) begin
      term_run = fwd_in;
      term_rev = rev_in;
    end
  end

  // Keypad latch
  always @* begin
    next_key_run = key_run;
    if (i_drive_mode != `MODE_KEYPAD || i_fault_active) begin
      next_key_run = 1'b0;
    end else if (i_stop_key) begin
      next_key_run = 1'b0;
    end else if (i_run_key) begin
      next_key_run = 1'b1;
    end
  end

  // Auto start gating: hold blocks an already active terminal
  always @* begin
    next_state = state;
    case (state)
      ST_INIT: begin
        // Map registers hold terminal levels only after the first edge
        if (!maps_ready) begin
          next_state = ST_INIT;
        end else if (term_mode && term_run && !i_power_on_autostart) begin
          next_state = ST_HOLD;
        end else begin
          next_state = ST_NORM;
        end
      end
      ST_NORM: begin
        if (i_fault_active) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (i_fault_active) begin
          next_state = ST_HOLD;
        end else if (!term_run) begin
          next_state = ST_NORM;
        end else if (fault_cleared && term_mode && i_fault_clear_autorestart) begin
          next_state = ST_NORM;
        end
      end
      default: next_state = ST_INIT;
    endcase
  end

  always @* begin
    if (i_drive_mode == `MODE_KEYPAD) begin
      want_run = key_run;
      want_rev = key_rev;
    end else begin
      want_run = term_run && (state == ST_NORM) && !i_fault_active;
      want_rev = term_rev;
    end
    next_reverse = want_run ? want_rev : o_reverse;
    next_run = want_run;
    if (want_run && !want_rev && i_direction_disable == `DIS_FWD) begin
      next_run = 1'b0;
    end
    if (want_run && want_rev && i_direction_disable == `DIS_REV) begin
      next_run = 1'b0;
    end
  end

  always @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_INIT;
      key_run <= 1'b0;
      key_rev <= 1'b0;
      fault_d <= 1'b0;
      maps_ready <= 1'b0;
      o_run <= 1'b0;
      o_reverse <= 1'b0;
    end else begin
      state <= next_state;
      key_run <= next_key_run;
      key_rev <= i_keypad_direction_select;
      fault_d <= i_fault_active;
      maps_ready <= 1'b1;
      o_run <= next_run;
      o_reverse <= next_reverse;
    end
  end
endmodule
`default_nettype wire

// ==== drive_run_command_select_props.sv ====
// Purpose: Timing relations of the run and direction outputs
// Assumes: Inputs 1 and 2 carry forward and reverse codes
// Notes: One clock domain
`timescale 1ns/1ps
`default_nettype none
module drive_run_props (
  input wire i_core_clk,
  input wire i_rst_b,
  input wire i_multi_input_1,
  input wire i_multi_input_2,
  input wire [1:0] i_drive_mode,
  input wire i_keypad_direction_select,
  input wire [1:0] i_direction_disable,
  input wire i_stop_key,
  input wire o_run,
  input wire o_reverse
);
  wire m0 = i_drive_mode == 2'h0;
  wire m1 = i_drive_mode == 2'h1;
  wire m2 = i_drive_mode == 2'h2;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  AST_M1_STOP: assert property (
    (m1 && i_multi_input_1 == i_multi_input_2)[*2] |=> !o_run) else $error("mode 1 no stop");
  AST_M1_DIR: assert property (
    (m1 && i_multi_input_1 != i_multi_input_2)[*2] |=>
    !o_run || o_reverse == $past(i_multi_input_2, 2)) else $error("mode 1 direction");
  AST_M2_STOP: assert property (
    (m2 && !i_multi_input_1)[*2] |=> !o_run) else $error("mode 2 no stop");
  AST_M2_DIR: assert property (
    (m2 && i_multi_input_1 && $stable(i_multi_input_2))[*2] |=>
    !o_run || o_reverse == $past(i_multi_input_2)) else $error("mode 2 direction");
  AST_NO_FWD: assert property (
    o_run && !o_reverse |-> $past(i_direction_disable) != 2'h1) else $error("forward not blocked");
  AST_NO_REV: assert property (
    o_run && o_reverse |-> $past(i_direction_disable) != 2'h2) else $error("reverse not blocked");
  AST_KEY_STOP: assert property (
    m0 && i_stop_key ##1 m0 |=> !o_run) else $error("stop key ignored");
  AST_KEY_DIR: assert property (
    o_run && $past(m0) |-> o_reverse == $past(i_keypad_direction_select, 2))
    else $error("keypad direction");
  cover property (o_run && o_reverse);
  cover property (o_run && !o_reverse);
  cover property (m0 && i_stop_key);
endmodule
bind drive_run_command_select drive_run_props u_props (.i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b), .i_multi_input_1(i_multi_input_1), .i_multi_input_2(i_multi_input_2),
  .i_drive_mode(i_drive_mode), .i_keypad_direction_select(i_keypad_direction_select),
  .i_direction_disable(i_direction_disable), .i_stop_key(i_stop_key), .o_run(o_run),
  .o_reverse(o_reverse));
`default_nettype wire

// ==== term_switch_model.sv ====
// Purpose: Switch bank driving the five terminals
// Assumes: Levels follow the bench requests
// Notes: Levels move 1 ns after the clock edge
`timescale 1ns/1ps
`default_nettype none
module term_switch_model (
  input wire i_core_clk,
  input wire [4:0] i_req,
  output logic [4:0] o_level
);
  initial o_level = 5'h00;
  always @(posedge i_core_clk) o_level <= #1 i_req;
endmodule
`default_nettype wire

// ==== drive_run_command_select_bench.sv ====
// Purpose: Self-checking bench for the run command select
// Assumes: Terminal codes fixed at 0, 1, 5, 6, 7
// Notes: Table first, then keypad, fault and power-up cases
`timescale 1ns/1ps
`default_nettype none
module drive_run_command_select_bench;
  logic clk = 1'b0, rst_b = 1'b0, kd = 1'b0, pa = 1'b0, fr = 1'b0, rk = 1'b0, sk = 1'b0;
  logic ft = 1'b0;
  logic [4:0] req = 5'h00;
  logic [4:0] lv;
  logic [1:0] md = 2'h1, ds = 2'h0, e;
  logic run, rev;
  logic [2:0] stp;
  logic [15:0] frq;
  logic [10:0] rows [13];
  int num_errors = 0, n_tests = 0;
  always #20 clk = ~clk;
  term_switch_model sw (.i_core_clk(clk), .i_req(req), .o_level(lv));
  drive_run_command_select uut (.i_core_clk(clk), .i_rst_b(rst_b), .i_multi_input_1(lv[0]),
    .i_multi_input_2(lv[1]), .i_multi_input_3(lv[2]), .i_multi_input_4(lv[3]),
    .i_multi_input_5(lv[4]), .i_input_function_codes(25'h0731420), .i_drive_mode(md),
    .i_keypad_direction_select(kd), .i_direction_disable(ds), .i_power_on_autostart(pa),
    .i_fault_clear_autorestart(fr), .i_run_key(rk), .i_stop_key(sk), .i_fault_active(ft),
    .i_base_freq(16'h0500), .i_preset_freq_1_to_3({16'h1003, 16'h1002, 16'h1001}),
    .i_preset_freq_4_to_7({16'h1007, 16'h1006, 16'h1005, 16'h1004}), .o_run(run),
    .o_reverse(rev), .o_step(stp), .o_freq(frq));
  function logic [15:0] ef(input logic [2:0] s);
    return (s == 3'h0) ? 16'h0500 : {13'h0200, s};
  endfunction
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input logic ok);
    n_tests++;
    if (!ok) begin
      num_errors++;
      $display("FAIL %0t check %0d", $time, n_tests);
    end
  endtask
  task rst(input logic [4:0] t);
    rst_b = 1'b0;
    req = t;
    cyc(10);
    rst_b = 1'b1;
  endtask
  task report_and_stop;
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    // Rows: mode, disable, terminals {step, rev, fwd}, {run, reverse}
    rows = '{{2'h1, 2'h0, 5'h00, 2'h0}, {2'h1, 2'h0, 5'h01, 2'h2}, {2'h1, 2'h0, 5'h06, 2'h3},
      {2'h1, 2'h0, 5'h0B, 2'h0}, {2'h1, 2'h0, 5'h0C, 2'h0}, {2'h2, 2'h0, 5'h11, 2'h2},
      {2'h2, 2'h0, 5'h17, 2'h3}, {2'h2, 2'h0, 5'h1A, 2'h0}, {2'h1, 2'h1, 5'h1D, 2'h0},
      {2'h1, 2'h1, 5'h02, 2'h3}, {2'h1, 2'h2, 5'h02, 2'h0}, {2'h2, 2'h2, 5'h01, 2'h2},
      {2'h3, 2'h0, 5'h01, 2'h0}};
    rst(5'h01);
    cyc(5);
    chk(run === 1'b0);
    foreach (rows[i]) begin
      {md, ds, req, e} = rows[i];
      cyc(5);
      chk(run === e[1] && (!e[1] || rev === e[0]) && stp === req[4:2] && frq === ef(req[4:2]));
    end
    md = 2'h0;
    ds = 2'h0;
    req = 5'h00;
    cyc(3);
    for (int d = 0; d < 2; d++) begin
      kd = d[0];
      rk = 1'b1;
      cyc(1);
      rk = 1'b0;
      cyc(3);
      chk(run === 1'b1 && rev === kd);
      sk = 1'b1;
      cyc(1);
      sk = 1'b0;
      cyc(3);
      chk(run === 1'b0);
    end
    md = 2'h1;
    req = 5'h01;
    cyc(5);
    for (int r = 1; r >= 0; r--) begin
      fr = r[0];
      ft = 1'b1;
      cyc(4);
      chk(run === 1'b0);
      ft = 1'b0;
      cyc(4);
      chk(run === r[0]);
    end
    req = 5'h00;
    cyc(4);
    chk(run === 1'b0);
    req = 5'h01;
    cyc(5);
    chk(run === 1'b1 && rev === 1'b0);
    md = 2'h0;
    fr = 1'b1;
    ft = 1'b1;
    cyc(3);
    ft = 1'b0;
    cyc(4);
    chk(run === 1'b0);
    pa = 1'b1;
    md = 2'h1;
    rst(5'h01);
    cyc(5);
    chk(run === 1'b1 && rev === 1'b0);
    md = 2'h0;
    rst(5'h01);
    cyc(5);
    chk(run === 1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
